// >>> core/sdr_defines.svh
// Offsets, field positions, codes and reset values for the SDRAM port
`ifndef SDR_DEFINES_SVH
`define SDR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_CMD 8'h04
`define OFS_WDATA 8'h08
`define OFS_STATUS 8'h0C
`define OFS_RDATA 8'h10

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define CTRL_RESET 4'h0
`define CTRL_RDLAT_LSB 0
`define CTRL_WRLAT_LSB 2
`define CMD_RESET 32'h0000_0000
`define CMD_CODE_LSB 0
`define CMD_SRC_BIT 3
`define CMD_DST_BIT 4
`define CMD_BANK_LSB 5
`define CMD_ADDR_LSB 8
`define STAT_BUSY 0
`define STAT_FULL 1
`define STAT_EMPTY 2
`define STAT_RDVALID 3
`define STRB_ALL 4'hF

// ----------------------------------------------------------------------------
// Command codes, pin patterns {row, col, write}
// ----------------------------------------------------------------------------
`define CODE_ACTIVATE 3'h0
`define CODE_DEACT_BANK 3'h1
`define CODE_DEACT_ALL 3'h2
`define CODE_REFRESH 3'h3
`define CODE_MODE_SET 3'h4
`define CODE_READ 3'h5
`define CODE_WRITE 3'h6
`define CODE_UNSUPPORTED 3'h7
`define PINS_NOP 3'h7
`define PINS_ACTIVATE 3'h3
`define PINS_DEACT 3'h2
`define PINS_REFRESH 3'h1
`define PINS_MODE_SET 3'h0
`define PINS_READ 3'h5
`define PINS_WRITE 3'h4
`define ALLBANK_BIT 10

// ----------------------------------------------------------------------------
// Timing and bus answers
// ----------------------------------------------------------------------------
`define CAS_LATENCY 3'h3
`define PHASE_ZERO 3'h0
`define PHASE_ONE 3'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> core/sdr_pkg.sv
// Types shared by the SDRAM port logic
package sdr_pkg;
    typedef enum logic {ST_IDLE, ST_ACTIVE} link_state_e;
    typedef logic [2:0] cmd_code_t;
endpackage

// >>> core/word_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != (PW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge aclk)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// >>> core/sdram_port_pdt_signalling.sv
// SDRAM command signalling with direct-transfer strobe, narrow port
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`include "sdr_defines.svh"

// Summary of operation
// - Shared strobe pins act as column strobe, write enable and row strobe.
// - Read direct-transfer strobe fires only when the source option bit is set.
// - Direct-transfer reads do not capture bus data; the peripheral takes it.
// - Read strobe delayed 0 to 3 cycles after data phase by read-latency field.
// - Write direct-transfer strobe fires only when the destination option bit is set.
// - Direct-transfer writes leave the data bus undriven.
// - Write strobe delayed 0 to 3 cycles after data phase by write-latency field.
// - Read data expected three clocks after the read column command.
// - Narrow port has no clock-enable output and no self-refresh.
module sdram_port_pdt_signalling
    import sdr_pkg::*;
#(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 16,
    parameter int FIFO_DEPTH = 8
)
(
    // System
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // SDRAM link
    input wire logic if_out_clock,
    output logic cs_n,
    output logic row_strobe_n,
    output logic col_strobe_n,
    output logic sdr_write_en_n,
    output logic [ADDR_W-1:0] sdr_addr,
    output logic [1:0] sdr_bank,
    output logic [DATA_W/8-1:0] sdr_be_n,
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    output logic direct_xfer_strobe
);
    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [1:0] clk_sync_reg;
    logic link_prev_reg;
    logic [DATA_W-1:0] dq_sync1_reg;
    logic [DATA_W-1:0] dq_sync2_reg;
    logic link_rise;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic do_write;
    logic is_wdata;
    logic [3:0] direct_xfer_ctrl_reg;
    logic [31:0] cmd_reg;
    logic cmd_pending_reg;
    logic [DATA_W-1:0] rd_data_reg;
    logic rd_valid_reg;
    link_state_e state_reg;
    cmd_code_t cur_code_reg;
    logic cur_src_reg;
    logic cur_dst_reg;
    logic [1:0] cur_lat_reg;
    logic [2:0] cur_end_reg;
    logic [2:0] phase_reg;
    logic [2:0] phase_next;
    logic [2:0] launch_end;
    logic [1:0] launch_lat;
    cmd_code_t launch_code;
    logic launch_src;
    logic launch_dst;
    logic launch;
    logic advance;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [DATA_W-1:0] fifo_out_data;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------------------
    // Link clock and data synchronisers
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clk_sync_reg <= 2'h0;
            link_prev_reg <= 1'b0;
        end
        else
        begin
            clk_sync_reg <= {clk_sync_reg[0], if_out_clock};
            link_prev_reg <= clk_sync_reg[1];
        end
    end

    // Same depth as the clock path so sampled data lines up with the edge
    always_ff @(posedge aclk)
    begin
        dq_sync1_reg <= dq_in;
        dq_sync2_reg <= dq_sync1_reg;
    end

    assign link_rise = clk_sync_reg[1] && !link_prev_reg;

    // ------------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------------
    assign is_wdata = (aw_addr_reg == `OFS_WDATA);
    // A full FIFO holds the response back, which stalls the master
    assign do_write = !awready && !wready && !bvalid && !(is_wdata && !fifo_in_ready);
    assign fifo_in_valid = do_write && is_wdata;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awready <= 1'b0;
                aw_addr_reg <= awaddr;
            end
            if (wvalid && wready)
            begin
                wready <= 1'b0;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
            if (do_write)
            begin
                bvalid <= 1'b1;
                unique case (aw_addr_reg)
                    `OFS_CTRL, `OFS_WDATA: bresp <= `RESP_OKAY;
                    `OFS_CMD: bresp <= (cmd_pending_reg || w_strb_reg != `STRB_ALL
                        || w_data_reg[`CMD_CODE_LSB +: 3] == `CODE_UNSUPPORTED)
                        ? `RESP_SLVERR : `RESP_OKAY;
                    default: bresp <= `RESP_SLVERR;
                endcase
            end
            if (bvalid && bready)
            begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Control and command registers
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            direct_xfer_ctrl_reg <= `CTRL_RESET;
        end
        else if (do_write && aw_addr_reg == `OFS_CTRL && w_strb_reg[0])
        begin
            direct_xfer_ctrl_reg <= w_data_reg[3:0];
        end
    end

    // A pending command or a partial write refuses a new command
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cmd_reg <= `CMD_RESET;
            cmd_pending_reg <= 1'b0;
        end
        else if (do_write && aw_addr_reg == `OFS_CMD && !cmd_pending_reg
            && w_strb_reg == `STRB_ALL && w_data_reg[`CMD_CODE_LSB +: 3] != `CODE_UNSUPPORTED)
        begin
            cmd_reg <= w_data_reg;
            cmd_pending_reg <= 1'b1;
        end
        else if (launch)
        begin
            cmd_pending_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end
        else
        begin
            if (arvalid && arready)
            begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rresp <= `RESP_OKAY;
                rdata <= 32'h0000_0000;
                unique case (araddr)
                    `OFS_CTRL: rdata[3:0] <= direct_xfer_ctrl_reg;
                    `OFS_CMD: rdata <= cmd_reg;
                    `OFS_WDATA: rdata <= 32'h0000_0000;
                    `OFS_STATUS:
                    begin
                        rdata[`STAT_BUSY] <= cmd_pending_reg || state_reg != ST_IDLE;
                        rdata[`STAT_FULL] <= !fifo_in_ready;
                        rdata[`STAT_EMPTY] <= !fifo_out_valid;
                        rdata[`STAT_RDVALID] <= rd_valid_reg;
                    end
                    `OFS_RDATA: rdata[DATA_W-1:0] <= rd_data_reg;
                    default: rresp <= `RESP_SLVERR;
                endcase
            end
            if (rvalid && rready)
            begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Command sequencing on link edges
    // ------------------------------------------------------------------------
    assign launch_code = cmd_reg[`CMD_CODE_LSB +: 3];
    assign launch_src = cmd_reg[`CMD_SRC_BIT];
    assign launch_dst = cmd_reg[`CMD_DST_BIT];
    assign launch = link_rise && state_reg == ST_IDLE && cmd_pending_reg
        && (launch_code != `CODE_WRITE || launch_dst || fifo_out_valid);
    assign advance = link_rise && state_reg == ST_ACTIVE;
    assign phase_next = phase_reg + 1'b1;
    assign fifo_pop = launch && launch_code == `CODE_WRITE && !launch_dst;

    // Data phase: CAS latency for reads, command edge for writes
    always_comb
    begin
        launch_lat = 2'h0;
        launch_end = `PHASE_ZERO;
        if (launch_code == `CODE_READ)
        begin
            launch_lat = direct_xfer_ctrl_reg[`CTRL_RDLAT_LSB +: 2];
            launch_end = `CAS_LATENCY + {1'b0, launch_lat};
        end
        else if (launch_code == `CODE_WRITE)
        begin
            launch_lat = direct_xfer_ctrl_reg[`CTRL_WRLAT_LSB +: 2];
            launch_end = {1'b0, launch_lat};
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= ST_IDLE;
            phase_reg <= `PHASE_ZERO;
            cur_code_reg <= `CODE_ACTIVATE;
            cur_src_reg <= 1'b0;
            cur_dst_reg <= 1'b0;
            cur_lat_reg <= 2'h0;
            cur_end_reg <= `PHASE_ZERO;
        end
        else if (launch)
        begin
            state_reg <= ST_ACTIVE;
            phase_reg <= `PHASE_ZERO;
            cur_code_reg <= launch_code;
            cur_src_reg <= launch_src;
            cur_dst_reg <= launch_dst;
            cur_lat_reg <= launch_lat;
            cur_end_reg <= launch_end;
        end
        else if (advance)
        begin
            phase_reg <= phase_next;
            if (phase_next >= cur_end_reg)
            begin
                state_reg <= ST_IDLE;
            end
        end
    end

    function automatic logic [2:0] pins_for(input cmd_code_t code);
        logic [2:0] pins;
        pins = `PINS_NOP;
        unique case (code)
            `CODE_ACTIVATE: pins = `PINS_ACTIVATE;
            `CODE_DEACT_BANK, `CODE_DEACT_ALL: pins = `PINS_DEACT;
            `CODE_REFRESH: pins = `PINS_REFRESH;
            `CODE_MODE_SET: pins = `PINS_MODE_SET;
            `CODE_READ: pins = `PINS_READ;
            `CODE_WRITE: pins = `PINS_WRITE;
            default: pins = `PINS_NOP;
        endcase
        return pins;
    endfunction

    // ------------------------------------------------------------------------
    // Pin drivers, all changed only on a link rising edge
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cs_n <= 1'b1;
            {row_strobe_n, col_strobe_n, sdr_write_en_n} <= `PINS_NOP;
            sdr_addr <= '0;
            sdr_bank <= 2'h0;
            sdr_be_n <= '1;
            dq_out <= '0;
            dq_oe <= 1'b0;
        end
        else if (launch)
        begin
            cs_n <= 1'b0;
            {row_strobe_n, col_strobe_n, sdr_write_en_n} <= pins_for(launch_code);
            sdr_addr <= cmd_reg[`CMD_ADDR_LSB +: ADDR_W];
            if (launch_code == `CODE_DEACT_ALL)
            begin
                sdr_addr[`ALLBANK_BIT] <= 1'b1;
            end
            else if (launch_code == `CODE_DEACT_BANK)
            begin
                sdr_addr[`ALLBANK_BIT] <= 1'b0;
            end
            sdr_bank <= cmd_reg[`CMD_BANK_LSB +: 2];
            sdr_be_n <= (launch_code == `CODE_READ || launch_code == `CODE_WRITE) ? '0 : '1;
            dq_out <= fifo_out_data;
            dq_oe <= fifo_pop;
        end
        else if (link_rise)
        begin
            cs_n <= 1'b1;
            {row_strobe_n, col_strobe_n, sdr_write_en_n} <= `PINS_NOP;
            sdr_be_n <= '1;
            dq_oe <= 1'b0;
        end
    end

    // Strobe lasts one link cycle at the delayed data phase
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            direct_xfer_strobe <= 1'b0;
        end
        else if (launch)
        begin
            direct_xfer_strobe <= launch_end == `PHASE_ZERO && launch_code == `CODE_WRITE
                && launch_dst;
        end
        else if (advance)
        begin
            direct_xfer_strobe <= phase_next == cur_end_reg
                && ((cur_code_reg == `CODE_READ && cur_src_reg)
                || (cur_code_reg == `CODE_WRITE && cur_dst_reg));
        end
        else if (link_rise)
        begin
            direct_xfer_strobe <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Read capture; a capture in the same cycle as a read of the read-data register wins
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_data_reg <= '0;
            rd_valid_reg <= 1'b0;
        end
        else if (advance && phase_next == `CAS_LATENCY && cur_code_reg == `CODE_READ
            && !cur_src_reg)
        begin
            rd_data_reg <= dq_sync2_reg;
            rd_valid_reg <= 1'b1;
        end
        else if (arvalid && arready && araddr == `OFS_RDATA)
        begin
            rd_valid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Write data FIFO
    // ------------------------------------------------------------------------
    word_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wdata_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(w_data_reg[DATA_W-1:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence seq_read_issue;
        launch && launch_code == `CODE_READ;
    endsequence

    sequence seq_read_pins;
        !cs_n && row_strobe_n && !col_strobe_n && sdr_write_en_n;
    endsequence

    chk_pins_on_edge: assert property (!link_rise |=> $stable({cs_n, row_strobe_n,
        col_strobe_n, sdr_write_en_n, dq_oe, direct_xfer_strobe}))
        else $error("link pins changed without a link edge");
    chk_read_strobes: assert property (seq_read_issue |=> seq_read_pins)
        else $error("read command pins wrong");
    chk_act_encoding: assert property (launch && launch_code == `CODE_ACTIVATE |=>
        !cs_n && !row_strobe_n && col_strobe_n && sdr_write_en_n)
        else $error("activate command pins wrong");
    chk_rd_gate: assert property ($rose(direct_xfer_strobe) && cur_code_reg == `CODE_READ
        |-> cur_src_reg)
        else $error("read strobe without source option");
    chk_wr_gate: assert property ($rose(direct_xfer_strobe) && cur_code_reg == `CODE_WRITE
        |-> cur_dst_reg && !dq_oe)
        else $error("write strobe without destination option");
    chk_no_capture: assert property ($rose(rd_valid_reg) |-> !cur_src_reg
        && cur_code_reg == `CODE_READ)
        else $error("direct read data captured");
    chk_write_hiz: assert property (dq_oe |-> !cur_dst_reg && cur_code_reg == `CODE_WRITE)
        else $error("data driven on direct write");
    chk_cas_three: assert property ($rose(rd_valid_reg) |-> phase_reg == `CAS_LATENCY)
        else $error("read data not sampled at CAS latency");
    chk_rd_latency: assert property ($rose(direct_xfer_strobe) && cur_code_reg == `CODE_READ
        |-> phase_reg == `CAS_LATENCY + {1'b0, cur_lat_reg})
        else $error("read strobe latency wrong");
    chk_wr_latency: assert property ($rose(direct_xfer_strobe) && cur_code_reg == `CODE_WRITE
        |-> phase_reg == {1'b0, cur_lat_reg})
        else $error("write strobe latency wrong");
endmodule

// >>> test/sdram_model.sv
// Behavioural SDRAM partner answering reads at CAS latency 3
module sdram_model #(
    parameter logic [15:0] RD_WORD = 16'hA5C3
)
(
    // Command pins
    input wire logic if_out_clock,
    input wire logic cs_n,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic sdr_write_en_n,
    // Data
    output logic [15:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] rd_pipe = 3'h0;
    logic [15:0] word = RD_WORD;
    initial dq_in = 16'h0000;
    // Word changes per read so a skipped capture shows
    always @(posedge if_out_clock)
    begin
        rd_pipe <= {rd_pipe[1:0], !cs_n && {row_strobe_n, col_strobe_n, sdr_write_en_n} == 3'h5};
        if (rd_pipe[1])
        begin
            dq_in <= word;
            word <= word + 16'h0001;
        end
        else
            dq_in <= ~dq_in;
    end
endmodule

// >>> test/tb.sv
// Register-level bench for the SDRAM port with direct-transfer strobe
`include "sdr_defines.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] RD_WORD = 16'hA5C3;
    localparam logic [2:0] PIN_TAB [5] = '{3'h3, 3'h2, 3'h2, 3'h1, 3'h0};
    logic aclk = 1'b0, aresetn = 1'b0, if_out_clock = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd_val;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, cs_n, row_strobe_n, col_strobe_n;
    logic sdr_write_en_n, dq_oe, direct_xfer_strobe, oe_seen, all_bit;
    logic [1:0] bresp, rresp, sdr_bank, sdr_be_n;
    logic [12:0] sdr_addr;
    logic [15:0] dq_in, dq_out, wr_word;
    logic [2:0] pins;
    int miscompares = 0, num_checks = 0, rises = 0, k, m;

    always #10 aclk = ~aclk;
    always #80 if_out_clock = ~if_out_clock;
    always @(posedge if_out_clock) rises++;

    sdram_port_pdt_signalling dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .if_out_clock, .cs_n, .row_strobe_n, .col_strobe_n,
        .sdr_write_en_n, .sdr_addr, .sdr_bank, .sdr_be_n, .dq_in, .dq_out, .dq_oe,
        .direct_xfer_strobe);
    sdram_model #(.RD_WORD(RD_WORD)) model_u (.if_out_clock, .cs_n, .row_strobe_n,
        .col_strobe_n, .sdr_write_en_n, .dq_in);

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
        num_checks++;
        if (got !== e)
        begin
            $display("mismatch %s expected %h seen %h", what, e, got);
            miscompares++;
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic hang(input string what);
        check(what, 32'h1, 32'h0);
        end_of_test();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1 && n < 300);
        if (n >= 300)
            hang("write answer");
        check("write resp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1 && n < 300);
        if (n >= 300)
            hang("read answer");
        rd_val = rdata;
        rready <= 1'b0;
        if (a != `OFS_STATUS || e != 32'h1)
            check("read data", e, rd_val);
        check("read resp", {30'h0, er}, {30'h0, rresp});
    endtask

    // Issues one command, then watches pins for eight link rises past launch
    task automatic cmd(input logic [2:0] code, input logic src, input logic dst,
                       input logic [12:0] addr);
        int n;
        wr(`OFS_CMD, {11'h0, addr, 3'h1, dst, src, code}, `RESP_OKAY);
        k = -1;
        m = -1;
        oe_seen = 1'b0;
        for (n = 0; n < 2000 && !(k >= 0 && rises - k > 7); n++)
        begin
            @(posedge aclk);
            if (k < 0 && cs_n === 1'b0)
            begin
                k = rises;
                pins = {row_strobe_n, col_strobe_n, sdr_write_en_n};
                all_bit = sdr_addr[`ALLBANK_BIT];
                wr_word = dq_out;
            end
            oe_seen = oe_seen | dq_oe;
            if (m < 0 && direct_xfer_strobe === 1'b1)
                m = rises;
        end
        if (k < 0)
            hang("command launch");
        for (n = 0; n < 50 && rd_val[`STAT_BUSY] !== 1'b0; n++)
            rdc(`OFS_STATUS, 32'h1, `RESP_OKAY);
    endtask

    // ------------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        check("idle pins", 32'h4, {29'h0, cs_n, dq_oe, direct_xfer_strobe});
        rdc(`OFS_CTRL, 32'h0, `RESP_OKAY);
        rdc(`OFS_STATUS, 32'h4, `RESP_OKAY);
        rdc(8'h20, 32'h0, `RESP_SLVERR);
        wr(`OFS_STATUS, 32'h0, `RESP_SLVERR);
        wr(`OFS_CMD, 32'h7, `RESP_SLVERR);
        $display("test reset and refusals done");
        for (int c = 0; c < 5; c++)
        begin
            cmd(3'(c), 1'b0, 1'b0, (c == 1) ? 13'h0400 : 13'h0000);
            check("command pins", {29'h0, PIN_TAB[c]}, {29'h0, pins});
            check("all-bank bit", {31'h0, c == 2}, {31'h0, all_bit});
        end
        $display("test command encodings done");
        cmd(`CODE_READ, 1'b0, 1'b0, 13'h0123);
        check("read pins", 32'h5, {29'h0, pins});
        check("read strobe", 32'hFFFF_FFFF, m);
        rdc(`OFS_STATUS, 32'hC, `RESP_OKAY);
        rdc(`OFS_RDATA, {16'h0, RD_WORD}, `RESP_OKAY);
        for (int l = 0; l < 4; l++)
        begin
            wr(`OFS_CTRL, l, `RESP_OKAY);
            cmd(`CODE_READ, 1'b1, 1'b0, 13'h0010);
            check("read strobe delay", 3 + l, m - k);
        end
        rdc(`OFS_STATUS, 32'h4, `RESP_OKAY);
        rdc(`OFS_RDATA, {16'h0, RD_WORD}, `RESP_OKAY);
        $display("test reads done");
        for (int l = 0; l < 4; l++)
        begin
            wr(`OFS_CTRL, l << 2, `RESP_OKAY);
            cmd(`CODE_WRITE, 1'b0, 1'b1, 13'h0020);
            check("write strobe delay", l, m - k);
            check("write bus released", 32'h0, {31'h0, oe_seen});
        end
        $display("test direct writes done");
        for (int i = 0; i < 8; i++)
            wr(`OFS_WDATA, 32'h1000 + i, `RESP_OKAY);
        rdc(`OFS_STATUS, 32'h2, `RESP_OKAY);
        for (int i = 0; i < 8; i++)
        begin
            cmd(`CODE_WRITE, 1'b0, 1'b0, 13'h0030);
            check("write data", 32'h1000 + i, {16'h0, wr_word});
            check("write pins", 32'h4, {29'h0, pins});
            check("write drive", 32'h1, {31'h0, oe_seen});
            check("write strobe", 32'hFFFF_FFFF, m);
        end
        rdc(`OFS_STATUS, 32'h4, `RESP_OKAY);
        $display("test buffered writes done");
        end_of_test();
    end
endmodule
